// *** dv/test_ebac_ctrl.sv ***
// self-checking bench for the byte-wide data store access controller
`timescale 1ns/1ps
module test_ebac_ctrl;
    import ebac_pkg::*;
    // ----------------------------------------------------------------
    // settings and signals
    // ----------------------------------------------------------------
    localparam int OSC_N = 8; // short programming count keeps the run brief
    localparam int OSC_P = 8; // ref_clk cycles per rc oscillator period
    logic ref_clk = 1'b0;
    logic rstn = 1'b0; // system reset, active low
    logic porRstn = 1'b0; // power-on reset, active low
    logic rcOsc = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_ADDR_W-1:0] paddr = '0;
    logic [APB_DATA_W-1:0] pwdata = '0;
    logic [APB_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic cpuStall;
    logic writeBusy;
    logic [2:0] oscDiv = 3'h0; // divider for the slow oscillator
    int stallTotal = 0; // cycles seen with the processor stalled
    int busyTotal = 0; // cycles seen with programming under way
    int errorCnt = 0;
    int totalChecks = 0;
    logic [15:0] lfsrQ = 16'h0063; // random source, fixed start
    logic [7:0] model [NV_BYTES]; // expected store contents
    // ----------------------------------------------------------------
    // design, clock and slow oscillator
    // ----------------------------------------------------------------
    ebac_ctrl #(.WRITE_OSC_CYCLES(OSC_N), .NV_BYTES(NV_BYTES)) dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .porRstn(porRstn), .rcOsc(rcOsc),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpuStall(cpuStall), .writeBusy(writeBusy));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // oscillator well below half the bus clock so every edge is counted
    always @(posedge ref_clk) begin
        oscDiv <= oscDiv + 3'h1;
        rcOsc <= oscDiv[2];
        stallTotal <= stallTotal + int'(cpuStall);
        busyTotal <= busyTotal + int'(writeBusy);
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] bit_word(input int pos);
        return 32'h1 << pos;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one transfer, entered just after an edge; the bus stays held so
    // a following transfer can start back to back
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 200) begin
            errorCnt++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
        logic err;
        apb(1'b0, a, 32'h0, v, err);
    endtask
    // poll busy before touching address or data, bounded
    task automatic wait_idle();
        logic [31:0] v;
        int i;
        for (i = 0; i < 400; i++) begin
            rd_reg(NV_CONTROL_OFF, v);
            if (v[WRITE_ENABLE_BUSY_POS] === 1'b0) break;
        end
        if (i == 400) begin
            errorCnt++;
            give_verdict();
        end
    endtask
    // guarded sequence: arm, then start on the very next transfer,
    // nothing may come between the two steps
    task automatic nv_write(input logic [11:0] a, input logic [7:0] d);
        wr_reg(NV_ADDRESS_OFF, {20'h0, a});
        wr_reg(NV_DATA_OFF, {24'h0, d});
        wr_reg(NV_CONTROL_OFF, bit_word(MASTER_WRITE_ENABLE_POS));
        wr_reg(NV_CONTROL_OFF, bit_word(WRITE_ENABLE_BUSY_POS));
    endtask
    // data register is read by the transfer right after the fetch
    task automatic nv_read(input logic [11:0] a, output logic [31:0] v);
        wr_reg(NV_ADDRESS_OFF, {20'h0, a});
        wr_reg(NV_CONTROL_OFF, bit_word(READ_ENABLE_POS));
        rd_reg(NV_DATA_OFF, v);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] v;
        logic e;
        logic [11:0] a;
        logic [7:0] d;
        logic [11:0] used [4];
        int s0;
        int b0;
        int k;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        porRstn <= 1'b1;
        @(posedge ref_clk);
        // reset contents of the three registers
        rd_reg(NV_DATA_OFF, v);
        check(v, {24'h0, NV_DATA_RST});
        rd_reg(NV_ADDRESS_OFF, v);
        check(v, {20'h0, NV_ADDRESS_RST});
        // a mapped access must answer without an error
        apb(1'b0, NV_ADDRESS_OFF, 32'h0, v, e);
        check({31'h0, e}, 32'h0);
        rd_reg(NV_CONTROL_OFF, v);
        check(v, 32'h0);
        // unmapped places answer with an error and zero data
        apb(1'b0, 12'h00c, 32'h0, v, e);
        check({v[30:0], e}, 32'h1);
        apb(1'b1, 12'hffc, 32'hffff_ffff, v, e);
        check({31'h0, e}, 32'h1);
        // start bit alone, or together with arming, must not program
        wr_reg(NV_CONTROL_OFF, bit_word(WRITE_ENABLE_BUSY_POS));
        idle(3);
        check({31'h0, writeBusy}, 32'h0);
        wr_reg(NV_CONTROL_OFF, 32'h6);
        idle(3);
        check({31'h0, writeBusy}, 32'h0);
        idle(8);
        // arming reads back, then lapses on its own
        wr_reg(NV_CONTROL_OFF, bit_word(MASTER_WRITE_ENABLE_POS));
        rd_reg(NV_CONTROL_OFF, v);
        check(v, bit_word(MASTER_WRITE_ENABLE_POS));
        idle(8);
        rd_reg(NV_CONTROL_OFF, v);
        check(v, 32'h0);
        wr_reg(NV_CONTROL_OFF, bit_word(WRITE_ENABLE_BUSY_POS));
        idle(3);
        check({31'h0, writeBusy}, 32'h0);
        // random and corner addresses, each written then fetched
        for (k = 0; k < 4; k++) begin
            lfsrQ = lfsr_next(lfsrQ);
            a = (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : lfsrQ[11:0];
            lfsrQ = lfsr_next(lfsrQ);
            d = lfsrQ[7:0];
            used[k] = a;
            wait_idle();
            s0 = stallTotal;
            b0 = busyTotal;
            // no flash self-program runs here, so busy is the only wait
            nv_write(a, d);
            model[a] = d;
            idle(2);
            check({31'h0, writeBusy}, 32'h1);
            rd_reg(NV_CONTROL_OFF, v);
            check(v & bit_word(WRITE_ENABLE_BUSY_POS), 32'h2);
            // a second guarded start while busy must be dropped
            wr_reg(NV_DATA_OFF, {24'h0, ~d});
            wr_reg(NV_CONTROL_OFF, bit_word(MASTER_WRITE_ENABLE_POS));
            wr_reg(NV_CONTROL_OFF, bit_word(WRITE_ENABLE_BUSY_POS));
            wait_idle();
            idle(4);
            check(stallTotal - s0, 2);
            v = ((busyTotal - b0) >= (OSC_N - 1) * OSC_P) &&
                ((busyTotal - b0) <= (OSC_N + 1) * OSC_P);
            check(v, 32'h1);
            s0 = stallTotal;
            nv_read(a, v);
            idle(6);
            check(v, {24'h0, d});
            check(stallTotal - s0, 4);
        end
        // a system reset in mid-write leaves programming running
        wait_idle();
        nv_write(12'h5a5, 8'h3c);
        model[12'h5a5] = 8'h3c;
        idle(3);
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        idle(1);
        check({31'h0, writeBusy}, 32'h1);
        wait_idle();
        nv_read(12'h5a5, v);
        check(v, 32'h3c);
        // every byte written in the loop keeps its own value
        for (k = 0; k < 4; k++) begin
            nv_read(used[k], v);
            check(v, {24'h0, model[used[k]]});
        end
        idle(2);
        give_verdict();
    end
    // ----------------------------------------------------------------
    // hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (50000) @(posedge ref_clk);
        errorCnt = errorCnt + 1;
        give_verdict();
    end
endmodule

// *** verilog/ebac_ctrl.sv ***
// apb slave for the byte-wide nonvolatile data store with guarded writes
`timescale 1ns/1ps
module ebac_ctrl #(
    parameter int WRITE_OSC_CYCLES = ebac_pkg::WRITE_OSC_CYCLES,
    parameter int NV_BYTES = ebac_pkg::NV_BYTES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic porRstn,
    input wire logic rcOsc,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ebac_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [ebac_pkg::APB_DATA_W-1:0] pwdata,
    output logic [ebac_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cpuStall,
    output logic writeBusy
);
    import ebac_pkg::*;

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    // the store is indexed by a full AW-bit address, so only powers of two avoid holes
    if (NV_BYTES < 2 || NV_BYTES > (1 << APB_ADDR_W) ||
        (NV_BYTES & (NV_BYTES - 1)) != 0) begin : g_chk
        $error("NV_BYTES must be a power of two within the address width");
    end

    localparam int AW = $clog2(NV_BYTES);
    localparam int MPE_WIN = MASTER_WINDOW_CYCLES + 1; // arming window plus the load edge

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] mem [0:NV_BYTES-1]; // the store itself, never reset
    logic [AW-1:0] addrReg_q; // selected byte
    logic [7:0] dataReg_q; // byte to write or byte fetched
    logic [2:0] mpeCnt_q; // cycles left in the arming window
    logic [2:0] stallCnt_q; // processor stall cycles left
    logic [2:0] stallCnt_d;
    logic cpuStall_q;
    logic pready_q;
    logic pslverr_q;
    logic [APB_DATA_W-1:0] prdata_q;
    logic [AW-1:0] wrAddr_q; // latched target, survives system reset
    logic [7:0] wrData_q; // latched byte, survives system reset
    logic timerBusy;
    logic timerDone;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire selCtrl = paddr == NV_CONTROL_OFF;
    wire selData = paddr == NV_DATA_OFF;
    wire selAddr = paddr == NV_ADDRESS_OFF;
    wire mapped = selCtrl | selData | selAddr;
    // a transfer is taken at the edge where pready is seen high
    wire xferDone = psel & penable & pready_q;
    wire wrOk = xferDone & pwrite & mapped;
    wire wrCtrl = wrOk & selCtrl;
    wire mpeArmed = mpeCnt_q != 3'h0;
    wire weReq = wrCtrl & pwdata[WRITE_ENABLE_BUSY_POS];
    // a write enable without a live arming window does nothing
    wire startWrite = weReq & mpeArmed & ~timerBusy;
    wire startRead = wrCtrl & pwdata[READ_ENABLE_POS] & ~timerBusy & ~startWrite;
    wire mpeLoad = wrCtrl & pwdata[MASTER_WRITE_ENABLE_POS] & ~startWrite;
    // the next access waits while the processor is stalled
    wire pready_d = psel & penable & ~pready_q & (stallCnt_q == 3'h0);
    wire [APB_DATA_W-1:0] ctrlRead = APB_DATA_W'({mpeArmed, timerBusy, 1'b0});
    wire [APB_DATA_W-1:0] readMux = selCtrl ? ctrlRead :
                                    selData ? APB_DATA_W'(dataReg_q) :
                                    selAddr ? APB_DATA_W'(addrReg_q) : '0;
    wire [7:0] memRdByte = mem[addrReg_q];

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cpuStall = cpuStall_q;
    assign writeBusy = timerBusy;

    // stall counter: four clocks for a fetch, two for a write start
    always_comb begin
        if (startRead) begin
            stallCnt_d = READ_STALL_CYCLES;
        end else if (startWrite) begin
            stallCnt_d = WRITE_STALL_CYCLES;
        end else if (stallCnt_q != 3'h0) begin
            stallCnt_d = stallCnt_q - 3'h1;
        end else begin
            stallCnt_d = 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------
    // answer flops: pready is a one cycle pulse per access
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pready_d & ~mapped; // unmapped gets an error
            prdata_q <= (pready_d && !pwrite) ? readMux : '0;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    // address and data registers, plus the fetch into the data register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            addrReg_q <= NV_ADDRESS_RST[AW-1:0];
            dataReg_q <= NV_DATA_RST;
        end else begin
            if (wrOk && selAddr) begin
                addrReg_q <= pwdata[AW-1:0];
            end
            if (startRead) begin
                dataReg_q <= memRdByte;
            end else if (wrOk && selData) begin
                dataReg_q <= pwdata[7:0];
            end
        end
    end

    // arming window: short so a stray later write enable cannot program
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mpeCnt_q <= 3'h0;
        end else if (startWrite) begin
            mpeCnt_q <= 3'h0;
        end else if (mpeLoad) begin
            mpeCnt_q <= MASTER_WINDOW_CYCLES;
        end else if (mpeArmed) begin
            mpeCnt_q <= mpeCnt_q - 3'h1;
        end
    end

    // stall output straight from a flop
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stallCnt_q <= 3'h0;
            cpuStall_q <= 1'b0;
        end else begin
            stallCnt_q <= stallCnt_d;
            cpuStall_q <= stallCnt_d != 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // programming path
    // ----------------------------------------------------------------
    // target latched at start; power-on reset only, so writes ride out rstn
    always_ff @(posedge ref_clk or negedge porRstn) begin
        if (!porRstn) begin
            wrAddr_q <= '0;
            wrData_q <= 8'h00;
        end else if (startWrite) begin
            wrAddr_q <= addrReg_q;
            wrData_q <= dataReg_q;
        end
    end

    // the byte lands when the timer finishes
    always_ff @(posedge ref_clk) begin
        if (timerDone) begin
            mem[wrAddr_q] <= wrData_q;
        end
    end

    ebac_write_timer #(
        .OSC_CYCLES(WRITE_OSC_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .porRstn(porRstn),
        .rcOsc(rcOsc),
        .start(startWrite),
        .busy(timerBusy),
        .done(timerDone)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_read_stall;
        @(posedge ref_clk) disable iff (!rstn)
        startRead |=> cpuStall_q [*4] ##1 !cpuStall_q;
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read stall not 4");

    property p_write_stall;
        @(posedge ref_clk) disable iff (!rstn)
        startWrite |=> cpuStall_q [*2] ##1 !cpuStall_q;
    endproperty
    a_write_stall: assert property (p_write_stall) else $error("write stall not 2");

    property p_start_busy;
        @(posedge ref_clk) disable iff (!rstn)
        startWrite |=> writeBusy && wrData_q == $past(dataReg_q);
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("write did not start");

    property p_read_data;
        @(posedge ref_clk) disable iff (!rstn)
        startRead |=> dataReg_q == $past(memRdByte);
    endproperty
    a_read_data: assert property (p_read_data) else $error("fetched byte wrong");

    property p_unarmed_ignored;
        @(posedge ref_clk) disable iff (!rstn)
        weReq && !mpeArmed && !writeBusy |=> !writeBusy;
    endproperty
    a_unarmed_ignored: assert property (p_unarmed_ignored) else $error("unarmed write ran");

    property p_mpe_clears;
        @(posedge ref_clk) disable iff (!rstn)
        mpeLoad |-> ##[1:MPE_WIN] !mpeArmed;
    endproperty
    a_mpe_clears: assert property (p_mpe_clears) else $error("arming never lapsed");

    property p_stall_blocks;
        @(posedge ref_clk) disable iff (!rstn)
        cpuStall_q |=> !pready_q;
    endproperty
    a_stall_blocks: assert property (p_stall_blocks) else $error("answered while stalled");

    property p_reset_keeps_write;
        @(posedge ref_clk) disable iff (!porRstn)
        writeBusy && !rstn && !timerDone |=> writeBusy || timerDone;
    endproperty
    a_reset_keeps_write: assert property (p_reset_keeps_write) else $error("reset aborted");

    property p_byte_stored;
        @(posedge ref_clk) disable iff (!porRstn)
        // past target, so a start in the done cycle cannot move the look-up
        timerDone |=> mem[$past(wrAddr_q)] == $past(wrData_q);
    endproperty
    a_byte_stored: assert property (p_byte_stored) else $error("byte not stored");

    c_read: cover property (@(posedge ref_clk) disable iff (!rstn) startRead);
    c_write: cover property (@(posedge ref_clk) disable iff (!rstn) startWrite);
    c_done: cover property (@(posedge ref_clk) disable iff (!porRstn) timerDone);
    c_refused: cover property (@(posedge ref_clk) disable iff (!rstn) weReq && !mpeArmed);
endmodule

// *** verilog/ebac_pkg.sv ***
// shared constants for the byte-wide data store access controller
package ebac_pkg;
    // ----------------------------------------------------------------
    // bus and store geometry
    // ----------------------------------------------------------------
    localparam int APB_ADDR_W = 12; // byte address width seen on apb
    localparam int APB_DATA_W = 32; // apb data width
    localparam int NV_BYTES = 4096; // size of the data store in bytes
    // ----------------------------------------------------------------
    // register offsets (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [APB_ADDR_W-1:0] NV_CONTROL_OFF = 12'h000;
    localparam logic [APB_ADDR_W-1:0] NV_DATA_OFF = 12'h004;
    localparam logic [APB_ADDR_W-1:0] NV_ADDRESS_OFF = 12'h008;
    // ----------------------------------------------------------------
    // control field positions
    // ----------------------------------------------------------------
    localparam int READ_ENABLE_POS = 0; // write one to fetch a byte
    localparam int WRITE_ENABLE_BUSY_POS = 1; // write one to program, reads busy
    localparam int MASTER_WRITE_ENABLE_POS = 2; // arms the write enable
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] NV_DATA_RST = 8'h00;
    localparam logic [11:0] NV_ADDRESS_RST = 12'h000;
    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    localparam logic [2:0] READ_STALL_CYCLES = 3'h4; // processor clocks
    localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2; // processor clocks
    localparam logic [2:0] MASTER_WINDOW_CYCLES = 3'h4; // arming lifetime
    localparam int WRITE_OSC_CYCLES = 26368; // rc oscillator cycles per write
    localparam real WRITE_TIME_MS = 3.3; // typical programming time
endpackage

// *** verilog/ebac_write_timer.sv ***
// self-timed programming timer counting rc oscillator cycles
`timescale 1ns/1ps
module ebac_write_timer #(
    parameter int OSC_CYCLES = ebac_pkg::WRITE_OSC_CYCLES
) (
    input wire logic ref_clk,
    input wire logic porRstn,
    input wire logic rcOsc,
    input wire logic start,
    output logic busy,
    output logic done
);
    import ebac_pkg::*;

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (OSC_CYCLES < 1) begin : g_chk
        $error("OSC_CYCLES must be at least one");
    end

    localparam int CW = $clog2(OSC_CYCLES + 1);

    logic oscMeta_q; // first synchroniser stage, read only by oscSync_q
    logic oscSync_q; // second stage
    logic oscPrev_q; // delayed copy for edge detection
    logic [CW-1:0] remain_q; // oscillator edges still to wait
    logic busy_q;
    logic done_q;
    logic [CW-1:0] riseCnt_q; // helper: edges seen during busy

    wire oscRise = oscSync_q & ~oscPrev_q;
    wire lastTick = busy_q & oscRise & (remain_q == CW'(1));

    assign busy = busy_q;
    assign done = done_q;

    // oscillator is asynchronous to ref_clk, two stages before any use
    always_ff @(posedge ref_clk or negedge porRstn) begin
        if (!porRstn) begin
            oscMeta_q <= 1'b0;
            oscSync_q <= 1'b0;
            oscPrev_q <= 1'b0;
        end else begin
            oscMeta_q <= rcOsc;
            oscSync_q <= oscMeta_q;
            oscPrev_q <= oscSync_q;
        end
    end

    // only power-on reset stops a write, so a system reset lets it finish
    always_ff @(posedge ref_clk or negedge porRstn) begin
        if (!porRstn) begin
            busy_q <= 1'b0;
            remain_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= lastTick;
            if (start && !busy_q) begin
                busy_q <= 1'b1;
                remain_q <= CW'(OSC_CYCLES);
            end else if (busy_q && oscRise) begin
                remain_q <= remain_q - CW'(1);
                if (lastTick) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // helper counter of oscillator edges while busy
    always_ff @(posedge ref_clk or negedge porRstn) begin
        if (!porRstn) begin
            riseCnt_q <= '0;
        end else if (start && !busy_q) begin
            riseCnt_q <= '0;
        end else if (busy_q && oscRise) begin
            riseCnt_q <= riseCnt_q + CW'(1);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_osc_count;
        @(posedge ref_clk) disable iff (!porRstn)
        $fell(busy_q) |-> riseCnt_q == CW'(OSC_CYCLES);
    endproperty
    a_osc_count: assert property (p_osc_count) else $error("write length wrong");

    property p_done_ends_busy;
        @(posedge ref_clk) disable iff (!porRstn)
        done_q |-> !busy_q && $past(busy_q);
    endproperty
    a_done_ends_busy: assert property (p_done_ends_busy) else $error("done without busy");
endmodule
